// [shared/bridge_seq_pkg.sv]
// constants shared by the full-bridge drive sequencer and its turn-on timer
// Contract
// [R1] toggle flip-flop alternates diagonal pairs each oscillator pulse
// [R2] each bridge drive on slightly under half period
// [R3] phase modulator sets diagonal overlap, hence duty
// [R4] pulse one: passive high, active low, rectifier two
// [R5] modulator trip: active low off, rectifier one on
// [R6] active high on after leg reaches input rail
// [R7] oscillator pulse: passive high, rectifier two off
// [R8] passive low on after leg nears ground
// [R9] pulse two end: mirrored active transition, low on
// [R10] missing zero-voltage event: force turn-on after timeout
// [R11] line sense tied high: fixed per-leg delays
// [R12] never both switches of one leg on
`default_nettype none
package bridge_seq_pkg;

  // timing
  localparam int CLK_PERIOD_NS        = 10;   // 100 MHz system clock
  localparam int DEFAULT_TIMEOUT_NS   = 400;  // turn-on timeout with program input at zero
  localparam int DEFAULT_TIMEOUT_CYCLES = DEFAULT_TIMEOUT_NS / CLK_PERIOD_NS;

  // widths
  localparam int DELAY_W = 8;                 // delay and timeout counters, in cycles

  // leg indices
  localparam int LEG_ACTIVE  = 0;
  localparam int LEG_PASSIVE = 1;
  localparam int LEG_COUNT   = 2;

  // reset values
  localparam logic DRIVE_RESET = 1'h0;        // all drives off
  localparam logic PHASE_RESET = 1'h0;        // first diagonal pair

endpackage
`default_nettype wire

// [design/zvs_turn_on_timer.sv]
// per-leg turn-on delay: zero-voltage sense, fixed delay or timeout
`timescale 1ns/10ps
`default_nettype none
module zvs_turn_on_timer #(
  parameter int DELAY_W = bridge_seq_pkg::DELAY_W
) (
  // clocking
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               clk_en,
  // control
  input  wire logic               clear,
  input  wire logic               start,
  input  wire logic               want_high,
  // sensing and programming
  input  wire logic               sense,
  input  wire logic               fixed_mode,
  input  wire logic [DELAY_W-1:0] fixed_delay,
  input  wire logic [DELAY_W-1:0] max_delay,
  // result
  output logic                    fire,
  output logic                    forced
);

  logic               busy;        // waiting for turn-on condition
  logic [DELAY_W-1:0] count;       // cycles spent waiting
  logic [DELAY_W-1:0] limit;       // effective timeout
  logic               sense_ok;    // leg has reached target rail
  logic               time_up;     // timeout reached
  logic               done;        // any turn-on condition

  // zero program value selects the open-input default
  assign limit    = (max_delay == '0) ?
                    DELAY_W'(bridge_seq_pkg::DEFAULT_TIMEOUT_CYCLES) : max_delay;
  assign time_up  = (count >= limit);                                    // [R10]
  // fixed mode ignores the leg sense and waits the programmed count
  assign sense_ok = fixed_mode ? (count >= fixed_delay)                  // [R11]
                               : (sense == want_high);                   // [R6] [R8]
  assign done     = sense_ok | time_up;

  // wait, then give one fire pulse
  always_ff @(posedge clk)
  begin
    if (rst || clear)
    begin
      busy   <= 1'h0;
      count  <= '0;
      fire   <= 1'h0;
      forced <= 1'h0;
    end
    else if (clk_en)
    begin
      fire   <= 1'h0;
      forced <= 1'h0;
      if (start)
      begin
        // restart: drive was just released
        busy  <= 1'h1;
        count <= '0;
      end
      else if (busy && done)
      begin
        busy   <= 1'h0;
        fire   <= 1'h1;
        forced <= ~sense_ok;                                             // [R10]
      end
      else if (busy)
      begin
        count <= count + 1'h1;
      end
    end
  end

endmodule
`default_nettype wire

// [design/phase_shift_bridge_sequencer.sv]
// six-output phase-shifted full-bridge drive sequencer
`timescale 1ns/10ps
`default_nettype none
module phase_shift_bridge_sequencer #(
  parameter int DELAY_W = bridge_seq_pkg::DELAY_W
) (
  // clocking
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               clk_en,
  // control events
  input  wire logic               chip_enable,
  input  wire logic               osc_pulse,
  input  wire logic               modulator_trip,
  // zero-voltage sensing
  input  wire logic               active_leg_sense,
  input  wire logic               passive_leg_sense,
  input  wire logic               line_sense_input,
  // delay programming
  input  wire logic [DELAY_W-1:0] timeout_program_input,
  input  wire logic [DELAY_W-1:0] active_fixed_delay,
  input  wire logic [DELAY_W-1:0] passive_fixed_delay,
  // gate drives
  output logic                    passive_high_drive,
  output logic                    passive_low_drive,
  output logic                    active_high_drive,
  output logic                    active_low_drive,
  output logic                    rectifier_one_drive,
  output logic                    rectifier_two_drive,
  // status
  output logic                    bridge_phase,
  output logic                    zero_voltage_turn_on,
  output logic                    forced_turn_on
);

  // sequencer states
  typedef enum logic [1:0] {
    st_off,
    st_power,
    st_freewheel
  } seq_state_t;

  seq_state_t state;                     // current operating state
  logic       start_ev;                  // enable seen while idle
  logic       osc_ev;                    // oscillator pulse while running
  logic       end_pulse;                 // power pulse ends now
  logic       clear_all;                 // chip disabled

  // per-leg arrays, index by package leg constants
  logic [1:0] leg_start;                 // leg drive released, start timer
  logic [1:0] leg_want;                  // target side at timer start
  logic [1:0] want_q;                    // held target side
  logic [1:0] leg_fire;                  // timer says turn on
  logic [1:0] leg_forced;                // turn-on came from timeout
  logic [1:0] leg_sense;                 // leg sense inputs
  logic [1:0] leg_high;                  // high-side drive flops
  logic [1:0] leg_low;                   // low-side drive flops
  logic [DELAY_W-1:0] leg_fixed [2];     // fixed delay per leg

  // event decode
  assign clear_all = ~chip_enable;
  assign start_ev  = chip_enable & (state == st_off);
  assign osc_ev    = chip_enable & osc_pulse & (state != st_off);
  // trip, or the oscillator arriving first, ends the pulse
  assign end_pulse = chip_enable & (state == st_power)
                   & (modulator_trip | osc_pulse);                      // [R3]

  // leg wiring
  assign leg_sense[bridge_seq_pkg::LEG_ACTIVE]  = active_leg_sense;
  assign leg_sense[bridge_seq_pkg::LEG_PASSIVE] = passive_leg_sense;
  assign leg_fixed[bridge_seq_pkg::LEG_ACTIVE]  = active_fixed_delay;
  assign leg_fixed[bridge_seq_pkg::LEG_PASSIVE] = passive_fixed_delay;

  // active leg releases on pulse end, passive on oscillator pulse
  assign leg_start[bridge_seq_pkg::LEG_ACTIVE]  = end_pulse;             // [R5] [R9]
  assign leg_start[bridge_seq_pkg::LEG_PASSIVE] = osc_ev;                // [R7]
  // phase 0: active goes low to high, passive high to low
  assign leg_want[bridge_seq_pkg::LEG_ACTIVE]   = ~bridge_phase;         // [R6] [R9]
  assign leg_want[bridge_seq_pkg::LEG_PASSIVE]  = bridge_phase;          // [R8]

  // operating state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= st_off;
    end
    else if (clk_en)
    begin
      if (clear_all)
      begin
        // disable drops to idle
        state <= st_off;
      end
      else if (start_ev || osc_ev)
      begin
        // new power pulse begins
        state <= st_power;
      end
      else if (end_pulse)
      begin
        // freewheel until the oscillator ends the half period
        state <= st_freewheel;
      end
      else
      begin
        state <= state;
      end
    end
  end

  // toggle flip-flop selecting the diagonal pair
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bridge_phase <= bridge_seq_pkg::PHASE_RESET;
    end
    else if (clk_en)
    begin
      if (start_ev)
      begin
        bridge_phase <= bridge_seq_pkg::PHASE_RESET;
      end
      else if (osc_ev)
      begin
        bridge_phase <= ~bridge_phase;                                   // [R1]
      end
    end
  end

  // per-leg drive flops and turn-on timers
  genvar g;
  generate
    for (g = 0; g < bridge_seq_pkg::LEG_COUNT; g++)
    begin : leg
      // target side kept for the timer
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          want_q[g] <= 1'h0;
        end
        else if (clk_en && leg_start[g])
        begin
          want_q[g] <= leg_want[g];
        end
      end

      // high and low drives of this leg
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          leg_high[g] <= bridge_seq_pkg::DRIVE_RESET;
          leg_low[g]  <= bridge_seq_pkg::DRIVE_RESET;
        end
        else if (clk_en)
        begin
          if (clear_all)
          begin
            // both off together, never one-sided
            leg_high[g] <= 1'h0;                                         // [R12]
            leg_low[g]  <= 1'h0;
          end
          else if (start_ev)
          begin
            // pulse one: passive high, active low
            leg_high[g] <= (g == bridge_seq_pkg::LEG_PASSIVE);           // [R4]
            leg_low[g]  <= (g == bridge_seq_pkg::LEG_ACTIVE);
          end
          else if (leg_start[g])
          begin
            // release: the on switch turns off, dead time follows
            leg_high[g] <= 1'h0;                                         // [R2]
            leg_low[g]  <= 1'h0;
          end
          else if (leg_fire[g] && want_q[g] && !leg_low[g])
          begin
            leg_high[g] <= 1'h1;                                         // [R6] [R12]
          end
          else if (leg_fire[g] && !want_q[g] && !leg_high[g])
          begin
            leg_low[g] <= 1'h1;                                          // [R8] [R9] [R12]
          end
        end
      end

      // waits for zero voltage, fixed delay or timeout
      zvs_turn_on_timer #(
        .DELAY_W     (DELAY_W)
      ) timer (
        .clk         (clk),
        .rst         (rst),
        .clk_en      (clk_en),
        .clear       (clear_all),
        .start       (leg_start[g]),
        .want_high   (want_q[g]),
        .sense       (leg_sense[g]),
        .fixed_mode  (line_sense_input),                                 // [R11]
        .fixed_delay (leg_fixed[g]),
        .max_delay   (timeout_program_input),                            // [R10]
        .fire        (leg_fire[g]),
        .forced      (leg_forced[g])
      );
    end
  endgenerate

  // drive outputs straight from the leg flops
  assign passive_high_drive = leg_high[bridge_seq_pkg::LEG_PASSIVE];
  assign passive_low_drive  = leg_low[bridge_seq_pkg::LEG_PASSIVE];
  assign active_high_drive  = leg_high[bridge_seq_pkg::LEG_ACTIVE];
  assign active_low_drive   = leg_low[bridge_seq_pkg::LEG_ACTIVE];

  // rectifier one: on at pulse-one end, off at pulse-two oscillator edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rectifier_one_drive <= bridge_seq_pkg::DRIVE_RESET;
    end
    else if (clk_en)
    begin
      if (clear_all || start_ev)
      begin
        rectifier_one_drive <= 1'h0;                                     // [R4]
      end
      else if (end_pulse && !bridge_phase)
      begin
        rectifier_one_drive <= 1'h1;                                     // [R5]
      end
      else if (osc_ev && bridge_phase)
      begin
        rectifier_one_drive <= 1'h0;
      end
    end
  end

  // rectifier two: mirror of rectifier one
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rectifier_two_drive <= bridge_seq_pkg::DRIVE_RESET;
    end
    else if (clk_en)
    begin
      if (clear_all)
      begin
        rectifier_two_drive <= 1'h0;
      end
      else if (start_ev)
      begin
        rectifier_two_drive <= 1'h1;                                     // [R4]
      end
      else if (end_pulse && bridge_phase)
      begin
        rectifier_two_drive <= 1'h1;
      end
      else if (osc_ev && !bridge_phase)
      begin
        rectifier_two_drive <= 1'h0;                                     // [R7]
      end
    end
  end

  // turn-on status pulses, sensed versus forced
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      zero_voltage_turn_on <= 1'h0;
      forced_turn_on       <= 1'h0;
    end
    else if (clk_en)
    begin
      // a disable in the fire cycle cancels the turn-on, so no status
      zero_voltage_turn_on <= ~clear_all & |(leg_fire & ~leg_forced);
      forced_turn_on       <= ~clear_all & |(leg_fire & leg_forced);     // [R10]
    end
  end

endmodule
`default_nettype wire

// [dv/bridge_seq_checker_sva.sv]
// concurrent checks on the sequencer's top-level ports
`timescale 1ns/10ps
`default_nettype none
module bridge_seq_checker #(
  parameter int DELAY_W = 8
) (
  // clocking
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               clk_en,
  // control
  input wire logic               chip_enable,
  input wire logic               osc_pulse,
  input wire logic               modulator_trip,
  input wire logic [DELAY_W-1:0] timeout_program_input,
  // drives and status
  input wire logic               passive_high_drive,
  input wire logic               passive_low_drive,
  input wire logic               active_high_drive,
  input wire logic               active_low_drive,
  input wire logic               rectifier_one_drive,
  input wire logic               rectifier_two_drive,
  input wire logic               bridge_phase,
  input wire logic               zero_voltage_turn_on,
  input wire logic               forced_turn_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [8:0] off_cnt;  // cycles with the active leg released
  logic [8:0] lim;      // turn-on limit in force
  logic       any_on;   // some bridge drive on
  assign lim = (timeout_program_input == '0) ?
               9'(bridge_seq_pkg::DEFAULT_TIMEOUT_CYCLES) : 9'(timeout_program_input);
  assign any_on = passive_high_drive | passive_low_drive | active_high_drive | active_low_drive;
  // count released cycles, cleared by any active drive or disable
  always_ff @(posedge clk)
  begin
    if (rst || !chip_enable || active_high_drive || active_low_drive)
      off_cnt <= 9'h000;
    else if (clk_en)
      off_cnt <= off_cnt + 9'h001;
  end
  a_passive_leg_excl: assert property (!(passive_high_drive && passive_low_drive))
    else $error("passive leg both on");
  a_active_leg_excl: assert property (!(active_high_drive && active_low_drive))
    else $error("active leg both on");
  a_phase_toggle: assert property (osc_pulse && clk_en && chip_enable && any_on |=>
    bridge_phase != $past(bridge_phase)) else $error("phase did not toggle");
  a_trip_ends_pulse: assert property (modulator_trip && active_low_drive && !bridge_phase
    && clk_en && chip_enable |=> !active_low_drive && rectifier_one_drive)
    else $error("trip did not end pulse one");
  a_osc_ends_free: assert property (osc_pulse && passive_high_drive && clk_en && chip_enable
    |=> !passive_high_drive && !rectifier_two_drive && bridge_phase)
    else $error("oscillator did not end freewheel");
  a_power_pair: assert property (passive_high_drive && active_low_drive
    |-> rectifier_two_drive && !rectifier_one_drive) else $error("pulse one rectifiers wrong");
  a_turn_on_gap: assert property ($rose(active_high_drive) |->
    !$past(active_low_drive) && !$past(active_low_drive, 2)) else $error("active turn-on too soon");
  a_status_rise: assert property (zero_voltage_turn_on || forced_turn_on |->
    $rose(passive_high_drive) || $rose(passive_low_drive) || $rose(active_high_drive)
    || $rose(active_low_drive)) else $error("status pulse without turn-on");
  a_timeout_bound: assert property (off_cnt <= lim + 9'h002)
    else $error("active turn-on overdue");
  a_disable_off: assert property (!chip_enable && clk_en |=> !any_on
    && !rectifier_one_drive && !rectifier_two_drive) else $error("drives on while disabled");
endmodule
bind phase_shift_bridge_sequencer bridge_seq_checker #(.DELAY_W(DELAY_W)) u_chk (.clk, .rst,
  .clk_en, .chip_enable, .osc_pulse, .modulator_trip, .timeout_program_input,
  .passive_high_drive, .passive_low_drive, .active_high_drive, .active_low_drive,
  .rectifier_one_drive, .rectifier_two_drive, .bridge_phase, .zero_voltage_turn_on,
  .forced_turn_on);
`default_nettype wire

// [dv/bridge_leg_model.sv]
// one bridge leg with its gate drivers, reporting where the leg sits
`timescale 1ns/10ps
`default_nettype none
module bridge_leg_model (
  // clocking
  input  wire logic       clk,
  input  wire logic       rst,
  // gate commands
  input  wire logic       high_drive,
  input  wire logic       low_drive,
  // leg behaviour
  input  wire logic [7:0] slew,
  input  wire logic       stuck,
  // leg sense, high at input rail
  output logic            sense
);
  logic [7:0] cnt;  // cycles since both switches let go
  // driven leg follows its switch, a released leg commutes after slew
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt   <= 8'h00;
      sense <= 1'h0;
    end
    else if (high_drive || low_drive)
    begin
      cnt   <= 8'h00;
      sense <= high_drive;
    end
    else if (!stuck && cnt != 8'hFF)
    begin
      cnt <= cnt + 8'h01;
      if (cnt + 8'h01 == slew)
        sense <= !sense;
    end
  end
endmodule
`default_nettype wire

// [dv/phase_shift_bridge_sequencer_bench.sv]
// self-checking bench for the full-bridge drive sequencer
`timescale 1ns/10ps
`default_nettype none
module phase_shift_bridge_sequencer_bench;
  typedef struct packed
  {
    logic       rs;     // restart first
    logic       line;   // fixed delay mode
    logic [7:0] fd;     // fixed delay, both legs
    logic [7:0] tpi;    // timeout program
    logic [7:0] slew;   // leg slew cycles
    logic       stuck;  // legs never commute
    logic       ev;     // 0 trip, 1 oscillator
    logic [1:0] d;      // drive awaited
    logic [7:0] gap;    // event to turn-on, cycles
    logic       frc;    // turn-on forced by timeout
    logic [6:0] snap;   // state one edge after event
  } step_t;
  logic       clk = 0, rst = 1, clk_en = 1, ce = 0, osc = 0, trip = 0;
  logic       line = 0, stuck = 0, as, ps, ph, pl, ah, al, r1, r2, phase, zvt, frc;
  logic [7:0] fd = 0, tpi = 0, slew = 1;
  int         n_mismatch = 0, tests_run = 0;
  wire  [6:0] st = {phase, r1, r2, ph, pl, ah, al};  // observed state
  wire  [3:0] drv = {ph, pl, ah, al};                 // bridge drives
  step_t steps [13] = '{
    '{1, 0, 0, 0, 1, 0, 0, 2, 3, 0, 'h38},
    '{0, 0, 0, 0, 1, 0, 1, 1, 3, 0, 'h62},
    '{0, 0, 0, 0, 1, 0, 0, 3, 3, 0, 'h74},
    '{0, 0, 0, 0, 1, 0, 1, 0, 3, 0, 'h11},
    '{1, 0, 0, 0, 6, 0, 0, 2, 8, 0, 'h38},
    '{1, 0, 0, 0, 1, 1, 0, 2, 42, 1, 'h38},
    '{0, 0, 0, 0, 1, 1, 1, 1, 42, 1, 'h62},
    '{1, 0, 0, 10, 1, 1, 0, 2, 12, 1, 'h38},
    '{1, 1, 2, 0, 1, 1, 0, 2, 4, 0, 'h38},
    '{0, 1, 2, 0, 1, 1, 1, 1, 4, 0, 'h62},
    '{1, 1, 20, 8, 1, 0, 0, 2, 10, 1, 'h38},
    '{1, 0, 0, 5, 8, 0, 0, 2, 7, 1, 'h38},
    '{1, 0, 0, 0, 1, 0, 1, 1, 3, 0, 'h60}
  };
  // design and the two legs it drives
  phase_shift_bridge_sequencer #(.DELAY_W(8)) DUT (.clk, .rst, .clk_en, .chip_enable(ce),
    .osc_pulse(osc), .modulator_trip(trip), .active_leg_sense(as), .passive_leg_sense(ps),
    .line_sense_input(line), .timeout_program_input(tpi), .active_fixed_delay(fd),
    .passive_fixed_delay(fd), .passive_high_drive(ph), .passive_low_drive(pl),
    .active_high_drive(ah), .active_low_drive(al), .rectifier_one_drive(r1),
    .rectifier_two_drive(r2), .bridge_phase(phase), .zero_voltage_turn_on(zvt),
    .forced_turn_on(frc));
  bridge_leg_model act (.clk, .rst, .high_drive(ah), .low_drive(al), .slew, .stuck, .sense(as));
  bridge_leg_model pas (.clk, .rst, .high_drive(ph), .low_drive(pl), .slew, .stuck, .sense(ps));
  // free-running clock
  initial forever #5 clk = ~clk;
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic cmp_state(input string what, input logic [6:0] exp, input logic [6:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_count(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("compared %0d, unexpected %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // disable, reset, apply settings, start pulse one
  task automatic restart(input step_t s);
    ce = 0;
    tick(2);
    cmp_state("disabled", 7'h00, {1'h0, st[5:0]});
    rst = 1;
    tick(1);
    rst = 0;
    {line, fd, tpi, slew, stuck} = {s.line, s.fd, s.tpi, s.slew, s.stuck};
    ce = 1;
    tick(2);
    cmp_state("start", 7'h19, st);
  endtask
  // one event, then time the awaited turn-on
  task automatic run_step(input step_t s);
    int n;
    if (s.rs)
      restart(s);
    tick(3);
    if (s.ev)
      osc = 1;
    else
      trip = 1;
    tick(1);
    osc = 0;
    trip = 0;
    tick(1);
    cmp_state("after event", s.snap, st);
    n = 1;
    while (drv[3-s.d] !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    cmp_count("turn-on gap", s.gap, 8'(n));
    cmp_state("status", {5'h00, !s.frc, s.frc}, {5'h00, zvt, frc});
    $display("step done, gap %0d", n);
  endtask
  // main sequence
  initial
  begin
    tick(8);
    cmp_state("reset", 7'h00, st);
    rst = 0;
    foreach (steps[i])
      run_step(steps[i]);
    rst = 1;
    tick(1);
    rst = 0;
    cmp_state("mid reset", 7'h00, st);
    tick(4);
    trip = 1;
    tick(2);
    trip = 0;
    tick(1);
    cmp_state("trip in freewheel", 7'h38, st);
    // clock enable low holds the pending turn-on back
    clk_en = 0;
    tick(3);
    cmp_state("frozen", 7'h38, st);
    clk_en = 1;
    tick(1);
    cmp_state("thawed", 7'h3A, st);
    cmp_state("thawed status", 7'h02, {5'h00, zvt, frc});
    $display("reset and repeated trip done");
    close_out();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("unexpected watchdog: expected end seen hang");
    close_out();
  end
endmodule
`default_nettype wire
